//--- design/icp_port.sv
// Purpose: serial interconnect port serving one link-layer port
// Assumes: requester and medium logic share sys_clk_i
// Notes: one connection; send data is copied into a tx FIFO
// Function
// - Connect refused when peer posted no listen
// - At most one connection per port pair
// - Serial port accepts only one pending listen
// - Bad local port or busy port rejected
// - Bad remote port rejected; good returns identifier
// - No connected indication without connect or listen
// - Establishment raises connected indication here
// - Send characters leave in strict request order
// - Send succeeds only after data copied
// - Send rejects bad connection, buffer, full queue
// - Second receive before indication gets pending status
// - Requester reposts receive after each indication
// - Received data is a plain byte stream
// - Close drains queued characters, then stops delivery
// - Send after close, or bad close, invalid
// - Port assigns identifier, quotes it in indications
// - No received indication after closed indication
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Character FIFO
// ----------------------------------------------------------------
module icp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i,
   // Fill level
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } fifo_st_t;

   fifo_st_t q;
   fifo_st_t d;
   logic push;
   logic pop;

   // Honest full and empty flags
   assign in_ready_o = q.cnt != (AW+1)'(DEPTH);
   assign out_valid_o = q.cnt != '0;
   assign out_data_o = q.mem[q.rd];
   assign level_o = q.cnt;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;

   // Pointer and count update, oldest word out first
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = in_data_i;
         d.wr = q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = q.rd + 1'b1;
      end
      case ({push, pop})
         2'b10: d.cnt = q.cnt + 1'b1;
         2'b01: d.cnt = q.cnt - 1'b1;
         default: d.cnt = q.cnt;
      endcase
   end

   // State register
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : icp_fifo

// ----------------------------------------------------------------
// Interconnect port
// ----------------------------------------------------------------
module icp_port (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Service request
   input wire logic req_valid_i,
   input wire icp_pkg::op_t req_op_i,
   input wire logic [icp_pkg::PORT_W-1:0] req_local_port_i,
   input wire logic [icp_pkg::PORT_W-1:0] req_remote_port_i,
   input wire logic [icp_pkg::CONN_W-1:0] req_conn_i,
   input wire logic req_buf_ok_i,
   input wire logic [icp_pkg::CNT_W-1:0] req_count_i,
   output logic req_ready_o,
   // Service response
   output logic rsp_valid_o,
   output logic [icp_pkg::STAT_W-1:0] rsp_status_o,
   output logic [icp_pkg::CONN_W-1:0] rsp_conn_o,
   // Send data
   input wire logic sdata_valid_i,
   input wire logic [icp_pkg::CHAR_W-1:0] sdata_i,
   output logic sdata_ready_o,
   // Indications
   output logic ind_valid_o,
   output icp_pkg::ind_t ind_kind_o,
   output logic [icp_pkg::CONN_W-1:0] ind_conn_o,
   output logic [icp_pkg::CNT_W-1:0] ind_count_o,
   input wire logic ind_ack_i,
   // Received characters
   output logic rd_valid_o,
   output logic [icp_pkg::CHAR_W-1:0] rd_data_o,
   // Medium side
   input wire logic peer_listen_i,
   input wire logic peer_connect_i,
   output logic tx_valid_o,
   output logic [icp_pkg::CHAR_W-1:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic rx_valid_i,
   input wire logic [icp_pkg::CHAR_W-1:0] rx_data_i,
   output logic rx_ready_o
);
   typedef struct packed {
      icp_pkg::req_st_t st;
      icp_pkg::conn_st_t cst;
      logic req_ready;
      logic rsp_valid;
      logic [icp_pkg::STAT_W-1:0] rsp_status;
      logic [icp_pkg::CONN_W-1:0] rsp_conn;
      logic sdata_ready;
      logic [icp_pkg::CNT_W-1:0] send_left;
      logic [icp_pkg::CONN_W-1:0] conn_id;
      logic conn_pend;
      logic rx_pend;
      logic rx_ready;
      logic [icp_pkg::CNT_W-1:0] rx_max;
      logic [icp_pkg::CNT_W-1:0] rx_cnt;
      logic rd_valid;
      logic [icp_pkg::CHAR_W-1:0] rd_data;
      logic ind_valid;
      icp_pkg::ind_t ind_kind;
      logic [icp_pkg::CONN_W-1:0] ind_conn;
      logic [icp_pkg::CNT_W-1:0] ind_count;
      logic tx_valid;
      logic [icp_pkg::CHAR_W-1:0] tx_data;
   } port_st_t;

   port_st_t q;
   port_st_t d;
   logic fire;
   logic sdata_fire;
   logic rx_fire;
   logic ind_free;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [icp_pkg::CHAR_W-1:0] fifo_out_data;
   logic [icp_pkg::LVL_W-1:0] fifo_lvl;
   logic [icp_pkg::LVL_W-1:0] tx_free;

   // Request names an established connection
   function automatic logic conn_ok(
      input icp_pkg::conn_st_t cst,
      input logic [icp_pkg::CONN_W-1:0] id,
      input logic [icp_pkg::CONN_W-1:0] req
   );
      conn_ok = (cst == icp_pkg::C_EST) && (id == req);
   endfunction : conn_ok

   // Handshake terms
   assign fire = req_valid_i && q.req_ready;
   assign sdata_fire = sdata_valid_i && q.sdata_ready && fifo_in_ready;
   assign rx_fire = rx_valid_i && q.rx_ready;
   assign ind_free = !q.ind_valid || ind_ack_i;
   assign fifo_pop = !q.tx_valid || tx_ready_i;
   assign tx_free = icp_pkg::FIFO_FULL_LVL - fifo_lvl;

   // Own copy of send data, drained in order
   icp_fifo #(
      .W(icp_pkg::CHAR_W),
      .DEPTH(icp_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i(sys_clk_i),
      .reset_i(reset_i),
      .in_valid_i(sdata_fire),
      .in_data_i(sdata_i),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out_data),
      .out_ready_i(fifo_pop),
      .level_o(fifo_lvl)
   );

   // Next-state logic
   always_comb begin
      d = q;
      d.rsp_valid = 1'b0;
      d.rd_valid = 1'b0;
      if (q.ind_valid && ind_ack_i) begin
         d.ind_valid = 1'b0;
      end
      // Transmit output stage
      if (fifo_pop) begin
         d.tx_valid = fifo_out_valid;
         d.tx_data = fifo_out_data;
      end
      // Request handling
      case (q.st)
         icp_pkg::RQ_IDLE: begin
            if (fire) begin
               d.rsp_valid = 1'b1;
               d.rsp_conn = req_conn_i;
               d.rsp_status = icp_pkg::ST_GOOD;
               case (req_op_i)
                  icp_pkg::OP_CONNECT, icp_pkg::OP_LISTEN: begin
                     d.rsp_conn = q.conn_id;
                     if (req_local_port_i != icp_pkg::LOCAL_PORT_ID) begin
                        d.rsp_status = icp_pkg::ST_INV_LOCAL;
                     end else if (q.cst != icp_pkg::C_IDLE) begin
                        d.rsp_status = icp_pkg::ST_LOCAL_IN_USE;
                     end else if (req_op_i == icp_pkg::OP_LISTEN) begin
                        d.conn_id = q.conn_id + 1'b1;
                        d.rsp_conn = d.conn_id;
                        d.cst = icp_pkg::C_LISTEN;
                     end else if (req_remote_port_i >
                                  icp_pkg::REMOTE_PORT_MAX) begin
                        d.rsp_status = icp_pkg::ST_INV_REMOTE;
                     end else if (!peer_listen_i) begin
                        d.rsp_status = icp_pkg::ST_PEER_NOT_WAITING;
                     end else begin
                        d.conn_id = q.conn_id + 1'b1;
                        d.rsp_conn = d.conn_id;
                        d.cst = icp_pkg::C_EST;
                        d.conn_pend = 1'b1;
                     end
                  end
                  icp_pkg::OP_SEND: begin
                     if (!conn_ok(q.cst, q.conn_id, req_conn_i)) begin
                        d.rsp_status = icp_pkg::ST_INV_CONN;
                     end else if (!req_buf_ok_i || req_count_i == '0) begin
                        d.rsp_status = icp_pkg::ST_INV_BUF;
                     end else if (req_count_i >
                                  icp_pkg::CNT_W'(tx_free)) begin
                        d.rsp_status = icp_pkg::ST_TX_QUEUE_FULL;
                     end else begin
                        // Collect the characters before answering
                        d.rsp_valid = 1'b0;
                        d.st = icp_pkg::RQ_SDATA;
                        d.send_left = req_count_i;
                        d.req_ready = 1'b0;
                        d.sdata_ready = 1'b1;
                     end
                  end
                  icp_pkg::OP_RECEIVE: begin
                     if (!conn_ok(q.cst, q.conn_id, req_conn_i)) begin
                        d.rsp_status = icp_pkg::ST_INV_CONN;
                     end else if (!req_buf_ok_i || req_count_i == '0) begin
                        d.rsp_status = icp_pkg::ST_INV_BUF;
                     end else if (q.rx_pend) begin
                        d.rsp_status = icp_pkg::ST_RX_PENDING;
                     end else begin
                        d.rx_pend = 1'b1;
                        d.rx_max = req_count_i;
                        d.rx_cnt = '0;
                     end
                  end
                  icp_pkg::OP_CLOSE: begin
                     if (!conn_ok(q.cst, q.conn_id, req_conn_i)) begin
                        d.rsp_status = icp_pkg::ST_INV_CONN;
                     end else begin
                        d.cst = icp_pkg::C_CLOSING;
                     end
                  end
                  default: begin
                     d.rsp_status = icp_pkg::ST_INV_CONN;
                  end
               endcase
            end
         end
         icp_pkg::RQ_SDATA: begin
            if (sdata_fire) begin
               d.send_left = q.send_left - 1'b1;
               if (q.send_left == 8'h01) begin
                  d.st = icp_pkg::RQ_IDLE;
                  d.sdata_ready = 1'b0;
                  d.req_ready = 1'b1;
                  d.rsp_valid = 1'b1;
                  d.rsp_status = icp_pkg::ST_GOOD;
                  d.rsp_conn = q.conn_id;
               end
            end
         end
         default: begin
            d.st = icp_pkg::RQ_IDLE;
            d.req_ready = 1'b1;
            d.sdata_ready = 1'b0;
         end
      endcase
      // Peer joined our pending listen
      if (q.cst == icp_pkg::C_LISTEN && peer_connect_i) begin
         d.cst = icp_pkg::C_EST;
         d.conn_pend = 1'b1;
      end
      // Received characters pass straight through
      if (rx_fire) begin
         d.rd_valid = 1'b1;
         d.rd_data = rx_data_i;
         d.rx_cnt = q.rx_cnt + 1'b1;
      end
      // Indications, one at a time
      if (ind_free) begin
         if (q.conn_pend) begin
            d.conn_pend = 1'b0;
            d.ind_valid = 1'b1;
            d.ind_kind = icp_pkg::IND_CONNECTED;
            d.ind_conn = q.conn_id;
            d.ind_count = '0;
         end else if (q.rx_pend && q.rx_cnt != '0 &&
                      (q.rx_cnt == q.rx_max || !rx_fire)) begin
            d.rx_pend = 1'b0;
            d.ind_valid = 1'b1;
            d.ind_kind = icp_pkg::IND_RECEIVED;
            d.ind_conn = q.conn_id;
            d.ind_count = q.rx_cnt;
         end else if (q.cst == icp_pkg::C_CLOSING && fifo_lvl == '0 &&
                      !q.tx_valid && !(q.rx_pend && q.rx_cnt != '0)) begin
            d.cst = icp_pkg::C_IDLE;
            d.rx_pend = 1'b0;
            d.ind_valid = 1'b1;
            d.ind_kind = icp_pkg::IND_CLOSED;
            d.ind_conn = q.conn_id;
            d.ind_count = '0;
         end
      end
      // Accept medium data only for an open receive
      d.rx_ready = d.rx_pend && d.cst == icp_pkg::C_EST &&
                   d.rx_cnt != d.rx_max;
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         q <= '0;
         q.st <= icp_pkg::RQ_IDLE;
         q.cst <= icp_pkg::C_IDLE;
         q.req_ready <= 1'b1;
         q.conn_id <= icp_pkg::CONN_ID_RST;
         q.ind_kind <= icp_pkg::IND_CONNECTED;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign req_ready_o = q.req_ready;
   assign rsp_valid_o = q.rsp_valid;
   assign rsp_status_o = q.rsp_status;
   assign rsp_conn_o = q.rsp_conn;
   assign sdata_ready_o = q.sdata_ready;
   assign ind_valid_o = q.ind_valid;
   assign ind_kind_o = q.ind_kind;
   assign ind_conn_o = q.ind_conn;
   assign ind_count_o = q.ind_count;
   assign rd_valid_o = q.rd_valid;
   assign rd_data_o = q.rd_data;
   assign tx_valid_o = q.tx_valid;
   assign tx_data_o = q.tx_data;
   assign rx_ready_o = q.rx_ready;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   // Connect without a waiting peer is refused
   AST_REFUSED: assert property (
      fire && req_op_i == icp_pkg::OP_CONNECT &&
      req_local_port_i == icp_pkg::LOCAL_PORT_ID &&
      req_remote_port_i <= icp_pkg::REMOTE_PORT_MAX &&
      q.cst == icp_pkg::C_IDLE && !peer_listen_i
      |=> rsp_valid_o && rsp_status_o == icp_pkg::ST_PEER_NOT_WAITING)
      else $error("connect without listener not refused");

   // Second connect on a busy port fails
   AST_ONE_CONN: assert property (
      fire && req_op_i == icp_pkg::OP_CONNECT &&
      req_local_port_i == icp_pkg::LOCAL_PORT_ID &&
      q.cst != icp_pkg::C_IDLE
      |=> rsp_status_o == icp_pkg::ST_LOCAL_IN_USE && $stable(q.conn_id))
      else $error("second connection accepted");

   // Only one pending listen
   AST_ONE_LISTEN: assert property (
      fire && req_op_i == icp_pkg::OP_LISTEN &&
      q.cst == icp_pkg::C_LISTEN
      |=> rsp_status_o != icp_pkg::ST_GOOD)
      else $error("second listen accepted");

   // Unknown local port rejected
   AST_BAD_LOCAL: assert property (
      fire && req_op_i inside {icp_pkg::OP_CONNECT, icp_pkg::OP_LISTEN} &&
      req_local_port_i != icp_pkg::LOCAL_PORT_ID
      |=> rsp_valid_o && rsp_status_o == icp_pkg::ST_INV_LOCAL)
      else $error("bad local port not rejected");

   // Connected indication only after connect or listen
   AST_NO_STRAY_CONN: assert property (
      $rose(ind_valid_o) && ind_kind_o == icp_pkg::IND_CONNECTED
      |-> q.cst inside {icp_pkg::C_EST, icp_pkg::C_CLOSING})
      else $error("connected without request");

   // Send larger than free space refused
   AST_TX_FULL: assert property (
      fire && req_op_i == icp_pkg::OP_SEND &&
      conn_ok(q.cst, q.conn_id, req_conn_i) && req_buf_ok_i &&
      req_count_i > icp_pkg::CNT_W'(tx_free)
      |=> rsp_status_o == icp_pkg::ST_TX_QUEUE_FULL)
      else $error("overfull send accepted");

   // Receive while one is outstanding
   AST_RX_PENDING: assert property (
      fire && req_op_i == icp_pkg::OP_RECEIVE && q.rx_pend &&
      conn_ok(q.cst, q.conn_id, req_conn_i) && req_buf_ok_i &&
      req_count_i != '0
      |=> rsp_status_o == icp_pkg::ST_RX_PENDING)
      else $error("second receive accepted");

   // Send after close is rejected
   AST_SEND_CLOSED: assert property (
      fire && req_op_i == icp_pkg::OP_SEND &&
      q.cst == icp_pkg::C_CLOSING
      |=> rsp_status_o == icp_pkg::ST_INV_CONN)
      else $error("send after close accepted");

   // Closed only once the queue has drained
   AST_CLOSE_DRAIN: assert property (
      d.ind_kind == icp_pkg::IND_CLOSED && d.ind_valid && !q.ind_valid
      |-> fifo_lvl == '0 && !tx_valid_o ##1 (!rx_ready_o) [*2])
      else $error("closed before drain");

   // Indication held stable until acknowledged
   AST_IND_HOLD: assert property (
      ind_valid_o && !ind_ack_i
      |=> ind_valid_o && $stable(ind_kind_o) && $stable(ind_count_o))
      else $error("indication dropped before ack");

endmodule : icp_port

//--- design/icp_pkg.sv
// Purpose: shared constants and types of the interconnect port
// Assumes: one clock, one serial connection per local port
// Notes: codes below are the status and indication encodings
package icp_pkg;

   // ----------------------------------------------------------
   // Widths and sizes
   // ----------------------------------------------------------
   localparam int CHAR_W = 8;
   localparam int CNT_W = 8;
   localparam int PORT_W = 4;
   localparam int CONN_W = 4;
   localparam int STAT_W = 4;
   localparam int LVL_W = 5;
   localparam int FIFO_DEPTH = 16;
   localparam logic [LVL_W-1:0] FIFO_FULL_LVL = 5'h10;

   // ----------------------------------------------------------
   // Port identifiers and reset values
   // ----------------------------------------------------------
   localparam logic [PORT_W-1:0] LOCAL_PORT_ID = 4'h0;
   localparam logic [PORT_W-1:0] REMOTE_PORT_MAX = 4'h7;
   localparam logic [CONN_W-1:0] CONN_ID_RST = 4'h0;

   // ----------------------------------------------------------
   // Service response codes
   // ----------------------------------------------------------
   localparam logic [STAT_W-1:0] ST_GOOD = 4'h0;
   localparam logic [STAT_W-1:0] ST_INV_LOCAL = 4'h1;
   localparam logic [STAT_W-1:0] ST_LOCAL_IN_USE = 4'h2;
   localparam logic [STAT_W-1:0] ST_INV_REMOTE = 4'h3;
   localparam logic [STAT_W-1:0] ST_PEER_NOT_WAITING = 4'h4;
   localparam logic [STAT_W-1:0] ST_INV_CONN = 4'h5;
   localparam logic [STAT_W-1:0] ST_INV_BUF = 4'h6;
   localparam logic [STAT_W-1:0] ST_TX_QUEUE_FULL = 4'h7;
   localparam logic [STAT_W-1:0] ST_RX_PENDING = 4'h8;

   // ----------------------------------------------------------
   // Requests, indications and states
   // ----------------------------------------------------------
   typedef enum logic [2:0] {
      OP_CONNECT = 3'h0, OP_LISTEN = 3'h1, OP_SEND = 3'h2,
      OP_RECEIVE = 3'h3, OP_CLOSE = 3'h4
   } op_t;
   typedef enum logic [1:0] {
      IND_CONNECTED = 2'h0, IND_RECEIVED = 2'h1, IND_CLOSED = 2'h2
   } ind_t;
   typedef enum logic [1:0] {
      RQ_IDLE = 2'b01, RQ_SDATA = 2'b10
   } req_st_t;
   typedef enum logic [3:0] {
      C_IDLE = 4'b0001, C_LISTEN = 4'b0010,
      C_EST = 4'b0100, C_CLOSING = 4'b1000
   } conn_st_t;

endpackage : icp_pkg

//--- testbench/icp_medium.sv
// Purpose: medium model on the far side of the port
// Assumes: shares the port clock
// Notes: stall_i holds tx back; idle rx data toggles
`timescale 1ns/1ns
module icp_medium (
   // Clock
   input wire logic clk_i,
   // Tx side
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   input wire logic stall_i,
   // Rx side
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   input wire logic rx_ready_i
);
   logic [7:0] txq[$];
   logic [7:0] rxq[$];
   // Take handshakes on the rising edge
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) txq.push_back(tx_data_i);
      if (rx_valid_o && rx_ready_i) void'(rxq.pop_front());
   end
   // Drive off the sampling edge
   always @(negedge clk_i) begin
      tx_ready_o <= !stall_i;
      rx_valid_o <= rxq.size() > 0;
      rx_data_o <= rxq.size() > 0 ? rxq[0] : ~rx_data_o;
   end
   initial begin
      tx_ready_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
   end
endmodule : icp_medium

//--- testbench/interconnect_connection_services_test.sv
// Purpose: self-checking bench of the interconnect port
// Assumes: bench plays the requester, icp_medium the medium
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
module interconnect_connection_services_test;
   logic clk, rst, rv, bo, sv, ack, pl, stall, rsp_seen, pc;
   icp_pkg::op_t op;
   icp_pkg::ind_t ik;
   logic [3:0] lp, rp, cn, rs, rc, ic, rsp_st;
   logic [7:0] cnt, sd, icnt, rd, td, xd;
   logic rr, rsv, sr, iv, rdv, tv, tr, xv, xr;
   logic [7:0] rdq[$];
   logic [7:0] sq[$];
   int failures, compares, i;

   icp_port dut (.sys_clk_i(clk), .reset_i(rst), .req_valid_i(rv),
      .req_op_i(op), .req_local_port_i(lp), .req_remote_port_i(rp),
      .req_conn_i(cn), .req_buf_ok_i(bo), .req_count_i(cnt),
      .req_ready_o(rr), .rsp_valid_o(rsv), .rsp_status_o(rs),
      .rsp_conn_o(rc), .sdata_valid_i(sv), .sdata_i(sd),
      .sdata_ready_o(sr), .ind_valid_o(iv), .ind_kind_o(ik),
      .ind_conn_o(ic), .ind_count_o(icnt), .ind_ack_i(ack),
      .rd_valid_o(rdv), .rd_data_o(rd), .peer_listen_i(pl),
      .peer_connect_i(pc), .tx_valid_o(tv), .tx_data_o(td),
      .tx_ready_i(tr), .rx_valid_i(xv), .rx_data_i(xd), .rx_ready_o(xr));
   icp_medium med (.clk_i(clk), .tx_valid_i(tv), .tx_data_i(td),
      .tx_ready_o(tr), .stall_i(stall), .rx_valid_o(xv),
      .rx_data_o(xd), .rx_ready_i(xr));

   // Clock of 100 ns
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Capture responses and delivered characters
   always @(negedge clk) begin
      if (rsv === 1'b1) begin
         rsp_seen = 1'b1;
         rsp_st = rs;
      end
      if (rdv === 1'b1) rdq.push_back(rd);
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic tmo(input string m);
      failures++;
      $display("CHECK FAILED at %0t: no %s", $time, m);
      end_of_test();
   endtask : tmo
   // Wait until a ready is seen, then pass its edge
   task automatic wpos(input int k);
      int n;
      for (n = 0; n < 50 && (k ? sr : rr) !== 1'b1; n++) @(negedge clk);
      if (n == 50) tmo("ready");
      @(posedge clk);
   endtask : wpos
   // One request, its send data from sq, then its status
   task automatic rq(input icp_pkg::op_t o, input logic [3:0] c,
      input logic [7:0] n, input logic [3:0] e);
      int w;
      @(negedge clk);
      rsp_seen = 1'b0;
      op = o;
      cn = c;
      cnt = n;
      rv = 1'b1;
      wpos(0);
      @(negedge clk);
      rv = 1'b0;
      foreach (sq[j]) begin
         sd = sq[j];
         sv = 1'b1;
         wpos(1);
         @(negedge clk);
      end
      sv = 1'b0;
      sd = ~sd; // Buffer reused once the request returns
      sq.delete();
      for (w = 0; w < 60 && !rsp_seen; w++) @(negedge clk);
      if (!rsp_seen) tmo("response");
      chk({4'h0, rsp_st}, {4'h0, e});
   endtask : rq
   // Wait for an indication, judge it, acknowledge it
   task automatic ind(input icp_pkg::ind_t k, input logic [7:0] n);
      int w;
      for (w = 0; w < 80 && iv !== 1'b1; w++) @(negedge clk);
      if (w == 80) tmo("indication");
      chk({6'h0, ik}, {6'h0, k});
      chk({4'h0, ic}, {4'h0, cn});
      if (k == icp_pkg::IND_RECEIVED) chk(icnt, n);
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
   endtask : ind

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_errors();
      lp = 4'h1;
      rq(icp_pkg::OP_CONNECT, 4'h0, 8'h00, icp_pkg::ST_INV_LOCAL);
      rq(icp_pkg::OP_LISTEN, 4'h0, 8'h00, icp_pkg::ST_INV_LOCAL);
      lp = 4'h0;
      rp = 4'h8;
      rq(icp_pkg::OP_CONNECT, 4'h0, 8'h00, icp_pkg::ST_INV_REMOTE);
      rp = 4'h3;
      rq(icp_pkg::OP_CONNECT, 4'h0, 8'h00,
         icp_pkg::ST_PEER_NOT_WAITING);
      rq(icp_pkg::OP_SEND, 4'h1, 8'h04, icp_pkg::ST_INV_CONN);
      rq(icp_pkg::OP_CLOSE, 4'h1, 8'h00, icp_pkg::ST_INV_CONN);
      chk({7'h0, iv}, 8'h00);
      $display("test errors done");
   endtask : t_errors
   task automatic t_connect();
      pl = 1'b1;
      rq(icp_pkg::OP_CONNECT, 4'h1, 8'h00, icp_pkg::ST_GOOD);
      chk({4'h0, rc}, 8'h01);
      ind(icp_pkg::IND_CONNECTED, 8'h00);
      rq(icp_pkg::OP_CONNECT, 4'h0, 8'h00, icp_pkg::ST_LOCAL_IN_USE);
      rq(icp_pkg::OP_LISTEN, 4'h0, 8'h00, icp_pkg::ST_LOCAL_IN_USE);
      $display("test connect done");
   endtask : t_connect
   task automatic t_send();
      int w;
      bo = 1'b0;
      rq(icp_pkg::OP_SEND, 4'h1, 8'h03, icp_pkg::ST_INV_BUF);
      bo = 1'b1;
      rq(icp_pkg::OP_SEND, 4'h1, 8'h00, icp_pkg::ST_INV_BUF);
      rq(icp_pkg::OP_SEND, 4'h2, 8'h01, icp_pkg::ST_INV_CONN);
      stall = 1'b1;
      sq = '{8'h11, 8'h22, 8'h33};
      rq(icp_pkg::OP_SEND, 4'h1, 8'h03, icp_pkg::ST_GOOD);
      for (w = 0; w < 13; w++) sq.push_back(8'h40 + 8'(w));
      rq(icp_pkg::OP_SEND, 4'h1, 8'h0d, icp_pkg::ST_GOOD);
      rq(icp_pkg::OP_SEND, 4'h1, 8'h02, icp_pkg::ST_TX_QUEUE_FULL);
      stall = 1'b0;
      for (w = 0; w < 200 && med.txq.size() < 16; w++) @(negedge clk);
      chk(8'(med.txq.size()), 8'h10);
      for (w = 0; w < 16 && w < med.txq.size(); w++)
         chk(med.txq[w], w < 3 ? 8'h11 * 8'(w + 1) : 8'h3d + 8'(w));
      $display("test send done");
   endtask : t_send
   task automatic t_receive();
      rq(icp_pkg::OP_RECEIVE, 4'h1, 8'h03, icp_pkg::ST_GOOD);
      rq(icp_pkg::OP_RECEIVE, 4'h1, 8'h03, icp_pkg::ST_RX_PENDING);
      med.rxq = '{8'ha1, 8'ha2};
      ind(icp_pkg::IND_RECEIVED, 8'h02);
      rq(icp_pkg::OP_RECEIVE, 4'h1, 8'h01, icp_pkg::ST_GOOD);
      med.rxq = '{8'hb1, 8'hb2};
      ind(icp_pkg::IND_RECEIVED, 8'h01);
      chk(8'(rdq.size()), 8'h03);
      chk(rdq[0], 8'ha1);
      chk(rdq[1], 8'ha2);
      chk(rdq[2], 8'hb1);
      $display("test receive done");
   endtask : t_receive
   task automatic t_close();
      int n;
      stall = 1'b1;
      sq = '{8'hc1, 8'hc2};
      rq(icp_pkg::OP_SEND, 4'h1, 8'h02, icp_pkg::ST_GOOD);
      rq(icp_pkg::OP_CLOSE, 4'h1, 8'h00, icp_pkg::ST_GOOD);
      rq(icp_pkg::OP_SEND, 4'h1, 8'h01, icp_pkg::ST_INV_CONN);
      chk({7'h0, iv}, 8'h00);
      stall = 1'b0;
      ind(icp_pkg::IND_CLOSED, 8'h00);
      chk(8'(med.txq.size()), 8'h12);
      chk(med.txq[med.txq.size() - 1], 8'hc2);
      n = rdq.size();
      repeat (10) @(negedge clk);
      chk(8'(rdq.size()), 8'(n));
      chk({7'h0, iv}, 8'h00);
      rq(icp_pkg::OP_CLOSE, 4'h1, 8'h00, icp_pkg::ST_INV_CONN);
      $display("test close done");
   endtask : t_close
   task automatic t_listen();
      rq(icp_pkg::OP_LISTEN, 4'h2, 8'h00, icp_pkg::ST_GOOD);
      chk({4'h0, rc}, 8'h02);
      rq(icp_pkg::OP_LISTEN, 4'h2, 8'h00, icp_pkg::ST_LOCAL_IN_USE);
      chk({7'h0, iv}, 8'h00);
      // Peer joins the pending listen
      pc = 1'b1;
      @(negedge clk);
      pc = 1'b0;
      ind(icp_pkg::IND_CONNECTED, 8'h00);
      $display("test listen done");
   endtask : t_listen

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      failures = 0;
      compares = 0;
      {rst, rv, sv, ack, pl, stall, rsp_seen, pc} = 8'h80;
      {lp, rp, cn, cnt, sd} = 28'h0;
      bo = 1'b1;
      rsp_st = 4'h0;
      op = icp_pkg::OP_CONNECT;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk({6'h0, rr, rsv}, 8'h02);
      t_errors();
      t_connect();
      t_send();
      t_receive();
      t_close();
      t_listen();
      end_of_test();
   end
endmodule : interconnect_connection_services_test
